// ### census_pkg.sv
/*
 * census_pkg: shared constants and carriers for the chain census register bank.
 * Assumes a single clock domain; register addresses are 16-bit word locations.
 */
package census_pkg;

    localparam int MAX_POS = 48;
    localparam logic [15:0] ADDR_PRESENT = 16'h0102;
    localparam logic [15:0] ADDR_CORRECT = 16'h0103;
    localparam logic [15:0] ADDR_WRONG = 16'h0104;
    localparam logic [15:0] ADDR_UNCONF = 16'h0105;
    localparam logic [15:0] ADDR_DEV_ID_BASE = 16'h0120;
    localparam logic [15:0] ADDR_CTRL_ID_BASE = 16'h0160;
    localparam logic [15:0] ADDR_CFG_BASE = 16'h01a0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] ID_RESET = 8'h00;
    localparam logic [7:0] OWN_ID_MIN = 8'h01;
    localparam logic [7:0] OWN_ID_MAX = 8'h30;
    localparam logic [7:0] OWN_ID_BAD_LO = 8'h31;
    localparam logic [7:0] CTRL_ID_BAD_LO = 8'hf8;
    localparam logic [7:0] ID_BLANK = 8'hff;
    localparam int OWN_STATUS_LSB = 0;
    localparam int CTRL_STATUS_LSB = 4;
    localparam int CFG_ERR_BIT = 8;

    typedef enum logic [2:0] {
        ST_ABSENT = 3'b000,
        ST_UNCONF = 3'b001,
        ST_CORRECT = 3'b010,
        ST_WRONG = 3'b011
    } cfg_status_t;

    // one end-device result delivered by the scan engine
    typedef struct packed {
        logic [5:0] pos;
        logic [7:0] own_id;
        logic [7:0] ctrl_id;
        logic comm_err;
    } scan_entry_t;

    // per-position stored census record
    typedef struct packed {
        logic present;
        logic [7:0] own_id;
        logic [7:0] ctrl_id;
        cfg_status_t own_status;
        cfg_status_t ctrl_status;
        logic err;
    } pos_record_t;

endpackage

// ### chain_census_regs.sv
/*
 * chain_census_regs: read-only result bank of the chain scan.
 * Assumes the scan engine is on mclk, reports one entry per position between
 * op_start and op_done, and that the register port is a simple word read port.
 */
// Behaviour
// - counters zero at reset, change at completion
// - present count equals detected devices
// - correct count equals correctly configured devices
// - correct: own id 1..48 equals position, controller matches
// - wrong count equals wrongly configured devices
// - wrong when neither correct nor unconfigured
// - unconfigured count equals unconfigured devices
// - unconfigured: both ids outside allowed ranges
// - records indexed 1..48 by chain position
// - ids captured from roll-call or autoconfig
// - ids read zero at reset, upper byte zero
// - ids refreshed only by chain operations
// - own status codes 0 absent 1 unconf 2 ok 3 wrong
// - own status derived from read-back own id
// - controller status bits 4-6, reset zero
// - bit 8 flags communication error
// - busy set during operation, clears at end
`timescale 1ns/1ps
module chain_census_regs #(
    parameter int NUM_POS = census_pkg::MAX_POS
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] controller_id,
    input wire logic op_start,
    input wire logic op_done,
    input wire logic entry_valid,
    input wire census_pkg::scan_entry_t entry,
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic controller_busy_flag
);

    // working set filled during the scan, published set read by software
    census_pkg::pos_record_t work [NUM_POS];
    census_pkg::pos_record_t next_work [NUM_POS];
    census_pkg::pos_record_t pub [NUM_POS];
    census_pkg::pos_record_t next_pub [NUM_POS];
    logic [15:0] present_device_count, correct_config_count;
    logic [15:0] wrong_config_count, unconfigured_count;
    logic [15:0] next_present, next_correct, next_wrong, next_unconf;
    logic next_busy;
    logic [15:0] next_rd_data;
    logic next_rd_valid;
    census_pkg::cfg_status_t ent_own, ent_ctrl;
    logic own_ok, ctrl_ok, own_blank, ctrl_blank;

    // classify the incoming entry against its position
    always_comb begin
        own_ok = (entry.own_id >= census_pkg::OWN_ID_MIN) &&
                 (entry.own_id <= census_pkg::OWN_ID_MAX) &&
                 (entry.own_id == {2'b00, entry.pos});
        ctrl_ok = (entry.ctrl_id == controller_id);
        own_blank = (entry.own_id == census_pkg::ID_RESET) ||
                    (entry.own_id >= census_pkg::OWN_ID_BAD_LO);
        ctrl_blank = (entry.ctrl_id == census_pkg::ID_RESET) ||
                     (entry.ctrl_id >= census_pkg::CTRL_ID_BAD_LO);
        // per-field status follows the id read back from that position
        if (own_ok) begin
            ent_own = census_pkg::ST_CORRECT;
        end else if (own_blank) begin
            ent_own = census_pkg::ST_UNCONF;
        end else begin
            ent_own = census_pkg::ST_WRONG;
        end
        if (ctrl_ok) begin
            ent_ctrl = census_pkg::ST_CORRECT;
        end else if (ctrl_blank) begin
            ent_ctrl = census_pkg::ST_UNCONF;
        end else begin
            ent_ctrl = census_pkg::ST_WRONG;
        end
    end

    // capture entries into the working set; publish everything at op_done
    always_comb begin
        next_work = work;
        next_pub = pub;
        next_present = present_device_count;
        next_correct = correct_config_count;
        next_wrong = wrong_config_count;
        next_unconf = unconfigured_count;
        next_busy = controller_busy_flag;
        if (op_start) begin
            next_busy = 1'b1;
            for (int i = 0; i < NUM_POS; i++) begin
                next_work[i] = '0;
            end
        end else if (controller_busy_flag && entry_valid && entry.pos != 6'h00 &&
                     entry.pos <= 6'(NUM_POS)) begin
            // position 1 is nearest the controller, stored at index 0
            next_work[entry.pos - 6'h01].present = 1'b1;
            next_work[entry.pos - 6'h01].own_id = entry.own_id;
            next_work[entry.pos - 6'h01].ctrl_id = entry.ctrl_id;
            next_work[entry.pos - 6'h01].own_status = ent_own;
            next_work[entry.pos - 6'h01].ctrl_status = ent_ctrl;
            next_work[entry.pos - 6'h01].err = entry.comm_err;
        end else if (controller_busy_flag && op_done) begin
            next_busy = 1'b0;
            next_pub = work;
            next_present = '0;
            next_correct = '0;
            next_wrong = '0;
            next_unconf = '0;
            for (int i = 0; i < NUM_POS; i++) begin
                if (work[i].present) begin
                    next_present = next_present + 16'h0001;
                    // a device is classed by both fields taken together
                    if (work[i].own_status == census_pkg::ST_CORRECT &&
                        work[i].ctrl_status == census_pkg::ST_CORRECT) begin
                        next_correct = next_correct + 16'h0001;
                    end else if (work[i].own_status == census_pkg::ST_UNCONF &&
                                 work[i].ctrl_status == census_pkg::ST_UNCONF) begin
                        next_unconf = next_unconf + 16'h0001;
                    end else begin
                        next_wrong = next_wrong + 16'h0001;
                    end
                end
            end
        end
    end

    // state registers; ids and counters only move on chain operations
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_POS; i++) begin
                work[i] <= '0;
                pub[i] <= '0;
            end
            present_device_count <= census_pkg::COUNT_RESET;
            correct_config_count <= census_pkg::COUNT_RESET;
            wrong_config_count <= census_pkg::COUNT_RESET;
            unconfigured_count <= census_pkg::COUNT_RESET;
            controller_busy_flag <= 1'b0;
        end else begin
            work <= next_work;
            pub <= next_pub;
            present_device_count <= next_present;
            correct_config_count <= next_correct;
            wrong_config_count <= next_wrong;
            unconfigured_count <= next_unconf;
            controller_busy_flag <= next_busy;
        end
    end

    // read decode; no write path exists so writes cannot disturb anything
    always_comb begin
        next_rd_data = 16'h0000;
        next_rd_valid = rd_en;
        case (rd_addr)
            census_pkg::ADDR_PRESENT: next_rd_data = present_device_count;
            census_pkg::ADDR_CORRECT: next_rd_data = correct_config_count;
            census_pkg::ADDR_WRONG: next_rd_data = wrong_config_count;
            census_pkg::ADDR_UNCONF: next_rd_data = unconfigured_count;
            default: begin
                for (int i = 0; i < NUM_POS; i++) begin
                    if (rd_addr == census_pkg::ADDR_DEV_ID_BASE + 16'(i)) begin
                        next_rd_data = {8'h00, pub[i].own_id};
                    end
                    if (rd_addr == census_pkg::ADDR_CTRL_ID_BASE + 16'(i)) begin
                        next_rd_data = {8'h00, pub[i].ctrl_id};
                    end
                    if (rd_addr == census_pkg::ADDR_CFG_BASE + 16'(i)) begin
                        next_rd_data = {7'h00, pub[i].err, 1'b0,
                                        pub[i].ctrl_status, 1'b0,
                                        pub[i].own_status};
                    end
                end
            end
        endcase
        if (!rd_en) begin
            next_rd_data = 16'h0000;
        end
    end

    // registered read answer, one cycle after the request
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

endmodule

// ### census_check_sva.sv
/* census_check_sva: port-level checks of the census register bank.
   assumes it is bound onto chain_census_regs, one mclk domain. */
`timescale 1ns/1ps
module census_check_sva #(
    parameter int NUM_POS = 48
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] controller_id,
    input wire logic op_start,
    input wire logic op_done,
    input wire logic entry_valid,
    input wire census_pkg::scan_entry_t entry,
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic controller_busy_flag
);
    // one domain, so clock and reset are declared once
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // read windows of the id tables, the record table and the present counter
    wire logic id_win = rd_en && rd_addr >= 16'h0120 && rd_addr < 16'h01a0;
    wire logic cfg_win = rd_en && rd_addr >= 16'h01a0 && rd_addr < 16'h01d0;
    wire logic cnt_rd = rd_en && rd_addr == 16'h0102;
    property p_busy_set; op_start |=> controller_busy_flag; endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not raised");
    property p_busy_clr; controller_busy_flag && op_done && !op_start && !entry_valid
        |=> !controller_busy_flag; endproperty
    a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared");
    property p_busy_hold; controller_busy_flag && !op_done |=> controller_busy_flag; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    property p_unmapped; rd_en && rd_addr == 16'h0100 |=> rd_valid && rd_data == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_id_hi; id_win |=> rd_valid && rd_data[15:8] == 8'h00; endproperty
    a_id_hi: assert property (p_id_hi) else $error("id upper byte set");
    property p_cfg_pad; cfg_win |=> rd_data[15:9] == 7'h00 && !rd_data[7] && !rd_data[3];
    endproperty
    a_cfg_pad: assert property (p_cfg_pad) else $error("unused record bit set");
    property p_codes; cfg_win |=> !rd_data[2] && !rd_data[6]; endproperty
    a_codes: assert property (p_codes) else $error("status code above 3");
    property p_cnt_stable; cnt_rd && !op_done ##1 !op_done ##1 cnt_rd
        |=> rd_data == $past(rd_data, 2); endproperty
    a_cnt_stable: assert property (p_cnt_stable) else $error("count moved without done");
    c_done: cover property (controller_busy_flag && op_done);
    c_data: cover property (rd_valid && rd_data != 16'h0000);
    c_stray: cover property (entry_valid && !controller_busy_flag);
endmodule

// ### chain_scan_model.sv
/* chain_scan_model: scan engine walking the chain of end-devices.
   assumes the bench fills the id arrays and calls scan. */
`timescale 1ns/1ps
module chain_scan_model (
    input wire logic mclk,
    input wire logic [7:0] own [1:48],
    input wire logic [7:0] ctl [1:48],
    input wire logic err [1:48],
    output logic op_start = 1'b0,
    output logic op_done = 1'b0,
    output logic entry_valid = 1'b0,
    output census_pkg::scan_entry_t entry = '1
);
    // stray skips op_start so every entry and the done pulse must be refused
    task automatic scan(input int n, input logic stray);
        @(posedge mclk);
        #1 op_start = !stray;
        for (int p = 1; p <= n; p++) begin
            @(posedge mclk);
            #1 op_start = 1'b0;
            entry_valid = 1'b1;
            entry = {6'(p), own[p], ctl[p], err[p]};
        end
        @(posedge mclk);
        #1 entry_valid = 1'b0;
        op_start = 1'b0;
        entry = ~entry; // released lines show no stale value
        op_done = 1'b1;
        @(posedge mclk);
        #1 op_done = 1'b0;
    endtask
endmodule

// ### bus_chain_census_registers_bench.sv
/* bus_chain_census_registers_bench: scans and reads of the census bank.
   assumes census_pkg, chain_census_regs, chain_scan_model, census_check_sva. */
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module bus_chain_census_registers_bench;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic rd_en = 1'b0;
    logic [15:0] rd_addr = 16'h0000;
    logic op_start, op_done, entry_valid, rd_valid, controller_busy_flag;
    logic [15:0] rd_data;
    census_pkg::scan_entry_t entry;
    logic [7:0] own [1:48];
    logic [7:0] ctl [1:48];
    logic err [1:48];
    logic [15:0] zero_addr [8] = '{16'h0102, 16'h0103, 16'h0104, 16'h0105,
        16'h0120, 16'h018f, 16'h01cf, 16'h0100};
    int bad_count = 0;
    int checked = 0;
    int cnt [4];
    always #4 mclk = ~mclk;
    chain_scan_model chain_scan_model_inst (.mclk(mclk), .own(own), .ctl(ctl), .err(err),
        .op_start(op_start), .op_done(op_done), .entry_valid(entry_valid), .entry(entry));
    chain_census_regs #(.NUM_POS(48)) chain_census_regs_inst (.mclk(mclk), .resetn(resetn),
        .controller_id(8'h05), .op_start(op_start), .op_done(op_done),
        .entry_valid(entry_valid), .entry(entry), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .controller_busy_flag(controller_busy_flag));
    // one word read, answer taken one cycle after the request
    task automatic rd(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge mclk);
        #1 rd_en = 1'b1;
        rd_addr = a;
        @(posedge mclk);
        #1 rd_en = 1'b0;
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data & m, e)
    endtask
    // class of one device seen at position p, controller id fixed at 05
    function automatic logic [2:0] cls(input int p, input logic [7:0] o, input logic [7:0] c);
        if (o == p && o >= 8'h01 && o <= 8'h30 && c == 8'h05) return 3'h2;
        if ((o == 8'h00 || o >= 8'h31) && (c == 8'h00 || c >= 8'hf8)) return 3'h1;
        return 3'h3;
    endfunction
    // status code of one id field: 2 match, 1 blank, 3 otherwise
    function automatic logic [2:0] fst(input logic ok, input logic blank);
        return ok ? 3'h2 : (blank ? 3'h1 : 3'h3);
    endfunction
    // every record of positions 1..n, the four counters and the first empty slot
    task automatic check_all(input int n);
        logic [2:0] s;
        cnt = '{0, 0, 0, 0};
        for (int p = 1; p <= n; p++) begin
            s = cls(p, own[p], ctl[p]);
            cnt[s]++;
            rd(16'h0120 + 16'(p - 1), 16'hffff, {8'h00, own[p]});
            rd(16'h0160 + 16'(p - 1), 16'hffff, {8'h00, ctl[p]});
            rd(16'h01a0 + 16'(p - 1), 16'hffff, {7'h00, err[p], 1'b0,
                fst(ctl[p] == 8'h05, ctl[p] == 8'h00 || ctl[p] >= 8'hf8), 1'b0,
                fst(own[p] == 8'(p) && own[p] >= 8'h01 && own[p] <= 8'h30,
                    own[p] == 8'h00 || own[p] >= 8'h31)});
        end
        rd(16'h0102, 16'hffff, 16'(n));
        rd(16'h0103, 16'hffff, 16'(cnt[2]));
        rd(16'h0104, 16'hffff, 16'(cnt[3]));
        rd(16'h0105, 16'hffff, 16'(cnt[1]));
        if (n < 48) rd(16'h01a0 + 16'(n), 16'hffff, 16'h0000);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // main sequence: full correct chain, mixed short chain, stray traffic, reset again
    initial begin
        for (int p = 1; p <= 48; p++) begin
            own[p] = 8'(p);
            ctl[p] = 8'h05;
            err[p] = 1'b0;
        end
        repeat (12) @(posedge mclk);
        #1 resetn = 1'b1;
        foreach (zero_addr[i]) rd(zero_addr[i], 16'hffff, 16'h0000);
        chain_scan_model_inst.scan(48, 1'b0);
        check_all(48);
        ctl[2] = 8'h06;
        own[3] = 8'hff;
        ctl[3] = 8'hff;
        own[4] = 8'h31;
        ctl[4] = 8'h00;
        ctl[5] = 8'hf8;
        own[6] = 8'h00;
        err[6] = 1'b1;
        fork
            chain_scan_model_inst.scan(6, 1'b0);
            repeat (2) rd(16'h0102, 16'hffff, 16'h0030);
        join
        check_all(6);
        own[1] = 8'h2a;
        chain_scan_model_inst.scan(6, 1'b1);
        rd(16'h0120, 16'hffff, 16'h0001);
        rd(16'h0102, 16'hffff, 16'h0006);
        @(posedge mclk);
        #1 resetn = 1'b0;
        repeat (2) @(posedge mclk);
        #1 resetn = 1'b1;
        foreach (zero_addr[i]) rd(zero_addr[i], 16'hffff, 16'h0000);
        summarize();
    end
endmodule
bind chain_census_regs census_check_sva #(.NUM_POS(NUM_POS)) census_check_sva_inst (
    .mclk(mclk), .resetn(resetn), .controller_id(controller_id), .op_start(op_start),
    .op_done(op_done), .entry_valid(entry_valid), .entry(entry), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .controller_busy_flag(controller_busy_flag));
